//--- hdl/active_energy_accumulator.v
// active_energy_accumulator.v: active power path, no-load and sign
// detection, energy accumulation and the byte register port.
// assumes: the core drives the register port on clk; samples come from
// logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "active_energy_regs.vh"

// Behaviour
// R1: power is current times voltage, low-pass filtered.
// R2: power scaled by one plus signed 12-bit gain over 4096.
// R3: signed 16-bit offset added, 256 counts per power count.
// R4: direction bit clear: flag sign change on positive to negative.
// R5: direction bit set: flag sign change on negative to positive.
// R6: sign flag with its enable holds interrupt until status cleared.
// R7: below no-load threshold skip accumulation and set low-power flag.
// R8: low-power flag with its enable holds interrupt until cleared.
// R9: no-load field 00 off; 01,10,11 pick 0.015,0.0075,0.0037 percent.
// R10: power added into hidden signed 49-bit accumulator each sample.
// R11: accumulation sample period is five clock cycles.
// R12: both mode bits clear: signed accumulation.
// R13: positive-only set: negative power ignored.
// R14: absolute set: magnitude accumulated; positive-only wins.
// R15: power divided by 8-bit unsigned divisor, zero means one.
// R16: energy register shows upper 24 accumulator bits.
// R17: read-clear view returns energy then clears upper 24 bits.
// R18: energy register wraps through full scale both ways.
// R19: enabled interrupts on half full and on overflow or underflow.
// R20: active power waveform samples at four selectable rates.
// R21: status flags stay set until software write clears them.
// R22: read and clear are atomic with accumulation.
module active_energy_accumulator #(
   parameter W = 24,
   parameter PW = 32,
   parameter LPF_SHIFT = 6,
   parameter WAVE_DIV = `AE_CLK_HZ / `AE_WAVE_RATE_HZ
) (
   input wire clk,
   input wire srst,
   input wire signed [W-1:0] currentSample,
   input wire signed [W-1:0] voltageSample,
   input wire sampleValid,
   input wire [7:0] sfrAddr,
   input wire [7:0] sfrWrData,
   input wire sfrWr,
   input wire sfrRd,
   output reg [7:0] sfrRdData,
   output wire measIrq,
   output reg signed [PW-1:0] waveSample,
   output reg waveValid
);
   localparam AW = `AE_ACC_WIDTH;
   localparam TW = `AE_TOTAL_WIDTH;
   localparam LOW = AW - TW;

   // no-load thresholds against full-scale power
   localparam [63:0] FS64 = 64'h1 << (PW - 1);
   localparam [63:0] NL_TH1 = FS64 * `AE_NL_PPM1 / `AE_PPM_DEN;
   localparam [63:0] NL_TH2 = FS64 * `AE_NL_PPM2 / `AE_PPM_DEN;
   localparam [63:0] NL_TH3 = FS64 * `AE_NL_PPM3 / `AE_PPM_DEN;

   // waveform tick: base count for the fastest rate
   localparam [31:0] WAVE_BASE = WAVE_DIV;

   // software-visible control registers
   reg [7:0] waveformSourceSelect;
   reg [7:0] lowLoadSetup;
   reg [7:0] accumulationSetup;
   reg [7:0] measureIrqEnableLow;
   reg [7:0] measureIrqEnableHigh;
   reg [7:0] measureIrqStatusLow;
   reg [11:0] powerGainWord;
   reg [15:0] powerOffsetWord;
   reg [7:0] energyDivisor;

   // datapath state
   wire signed [PW-1:0] activePower;
   reg signed [AW-1:0] acc;
   reg [2:0] tickCount;
   reg prevNeg;
   reg signSeen;
   reg [TW-1:0] energySnap;
   reg [31:0] waveCount;

   // power filter, gain and offset
   power_lowpass #(
      .W(W),
      .PW(PW),
      .LPF_SHIFT(LPF_SHIFT)
   ) uPower (
      .clk(clk),
      .srst(srst),
      .currentSample(currentSample),
      .voltageSample(voltageSample),
      .sampleValid(sampleValid),
      .powerGainWord(powerGainWord),
      .powerOffsetWord(powerOffsetWord),
      .activePower(activePower)
   );

   // decoded mode bits
   wire posOnly = accumulationSetup[`AE_ACC_POS_ONLY];
   wire absMode = accumulationSetup[`AE_ACC_ABS];
   wire signDir = accumulationSetup[`AE_ACC_SIGN_DIR];
   wire [1:0] noLoadSel = lowLoadSetup[`AE_NL_LSB+1:`AE_NL_LSB];
   wire [1:0] waveRate =
      waveformSourceSelect[`AE_WAVE_RATE_LSB+1:`AE_WAVE_RATE_LSB];
   wire [2:0] waveSrc =
      waveformSourceSelect[`AE_WAVE_SRC_LSB+2:`AE_WAVE_SRC_LSB];

   // accumulation tick every five cycles
   // free-running from reset; it never waits on sample strobes
   wire accTick = (tickCount == `AE_ACC_PERIOD - 3'd1); // R11

   always @(posedge clk) begin
      if (srst)
         tickCount <= 3'd0;
      else if (accTick)
         tickCount <= 3'd0;
      else
         tickCount <= tickCount + 3'd1; // R11
   end

   // magnitude of active power
   // the most negative power maps to its true unsigned size
   wire powerNeg = activePower[PW-1];
   wire [PW-1:0] powerMag = powerNeg ? -activePower : activePower;
   wire [63:0] mag64 = {{(64-PW){1'b0}}, powerMag};

   // no-load threshold select
   // thresholds are fixed at build time, so no divider is needed
   reg [63:0] noLoadTh;
   always @* begin
      case (noLoadSel)
         2'b01: noLoadTh = NL_TH1; // R9
         2'b10: noLoadTh = NL_TH2; // R9
         2'b11: noLoadTh = NL_TH3; // R9
         default: noLoadTh = 64'h0; // R9
      endcase
   end

   wire noLoad = (noLoadSel != 2'b00) && (mag64 < noLoadTh); // R7

   // contribution by accumulation mode
   // positive-only is tested first so it wins over absolute
   reg signed [PW:0] selPower;
   always @* begin
      if (posOnly)
         selPower = powerNeg ? {(PW+1){1'b0}} :
            {1'b0, activePower}; // R13 R14
      else if (absMode)
         selPower = {1'b0, powerMag}; // R14
      else
         selPower = {activePower[PW-1], activePower}; // R12
   end

   // divide, zero divisor taken as one
   // a zero top bit keeps the divisor positive in signed division
   wire [7:0] divEff = (energyDivisor == 8'h00) ? 8'h01 :
      energyDivisor; // R15
   wire signed [8:0] divS = {1'b0, divEff};
   wire signed [PW:0] quot = selPower / divS; // R15
   wire signed [AW-1:0] addend =
      {{(AW-PW-1){quot[PW]}}, quot};

   // read-clear request this cycle
   wire rcRead = sfrRd && (sfrAddr == `AE_ADDR_RC_LO);
   wire snapRead = rcRead || (sfrRd && (sfrAddr == `AE_ADDR_EN_LO));
   wire doAdd = accTick && !noLoad; // R7 R10

   // clear the top, keep the low part, then add in the same edge
   // an add that lands on the read-clear edge goes into the cleared
   // value, so no step is lost between the read and the clear
   wire signed [AW-1:0] accBase = rcRead ?
      {{TW{1'b0}}, acc[LOW-1:0]} : acc; // R17 R22
   wire signed [AW-1:0] next_acc = doAdd ? accBase + addend :
      accBase; // R10 R18

   // accumulator register, wraps in two's complement
   always @(posedge clk) begin
      if (srst)
         acc <= {AW{1'b0}};
      else
         acc <= next_acc; // R10 R18 R22
   end

   // threshold crossings of the visible top
   // the sign of the addend tells a wrap upward from one downward
   wire [1:0] topOld = accBase[AW-1:AW-2];
   wire [1:0] topNew = next_acc[AW-1:AW-2];
   wire addPos = !addend[AW-1];
   wire halfPos = doAdd && topOld == 2'b00 && topNew == 2'b01; // R19
   wire halfNeg = doAdd && topOld == 2'b11 && topNew == 2'b10; // R19
   wire overflow = doAdd && addPos && topOld == 2'b01 &&
      topNew == 2'b10; // R18 R19
   wire underflow = doAdd && !addPos && topOld == 2'b10 &&
      topNew == 2'b01; // R18 R19

   // sign change detection at each accumulation sample
   // the first tick after reset only records the sign, so power that
   // starts out negative raises no false flag
   wire toNeg = signSeen && !prevNeg && powerNeg;
   wire toPos = signSeen && prevNeg && !powerNeg;
   wire signEvt = accTick &&
      (signDir ? toPos : toNeg); // R4 R5

   always @(posedge clk) begin
      if (srst) begin
         prevNeg <= 1'b0;
         signSeen <= 1'b0;
      end else if (accTick) begin
         prevNeg <= powerNeg;
         signSeen <= 1'b1;
      end
   end

   // waveform sampling of active power
   // a count at or past the limit fires, so a faster rate acts at once
   wire waveOn = measureIrqEnableHigh[`AE_EN_WAVE] &&
      (waveSrc == `AE_WAVE_SRC_ACTIVE); // R20
   wire [31:0] waveLimit = (WAVE_BASE << waveRate) - 32'd1; // R20
   wire waveTick = waveOn && (waveCount >= waveLimit);

   always @(posedge clk) begin
      if (srst) begin
         waveCount <= 32'd0;
         waveSample <= {PW{1'b0}};
         waveValid <= 1'b0;
      end else begin
         waveValid <= waveTick; // R20
         if (!waveOn || waveTick)
            waveCount <= 32'd0;
         else
            waveCount <= waveCount + 32'd1;
         if (waveTick)
            waveSample <= activePower; // R20
      end
   end

   // hardware set events for the status register
   reg [7:0] setEvents;
   always @* begin
      setEvents = 8'h00;
      setEvents[`AE_ST_SIGN] = signEvt; // R4 R5
      setEvents[`AE_ST_NOLOAD] = accTick && noLoad; // R7
      setEvents[`AE_ST_HALF_POS] = halfPos; // R19
      setEvents[`AE_ST_HALF_NEG] = halfNeg; // R19
      setEvents[`AE_ST_OVER] = overflow; // R19
      setEvents[`AE_ST_UNDER] = underflow; // R19
      setEvents[`AE_ST_WAVE] = waveTick; // R20
   end

   // write-one-to-clear, a set in the same cycle wins
   wire stWrite = sfrWr && (sfrAddr == `AE_ADDR_IRQST_LO);
   wire [7:0] clrMask = stWrite ? sfrWrData : 8'h00;

   always @(posedge clk) begin
      if (srst)
         measureIrqStatusLow <= `AE_RST_BYTE;
      else
         measureIrqStatusLow <= (measureIrqStatusLow & ~clrMask) |
            setEvents; // R21
   end

   // pending interrupt while any enabled flag is set
   // clearing an enable drops the request but keeps the flag
   assign measIrq = |(measureIrqStatusLow &
      measureIrqEnableLow); // R6 R8 R19

   // control register writes
   always @(posedge clk) begin
      if (srst) begin
         waveformSourceSelect <= `AE_RST_BYTE;
         lowLoadSetup <= `AE_RST_BYTE;
         accumulationSetup <= `AE_RST_BYTE;
         measureIrqEnableLow <= `AE_RST_BYTE;
         measureIrqEnableHigh <= `AE_RST_BYTE;
         powerGainWord <= `AE_RST_GAIN;
         powerOffsetWord <= `AE_RST_OFS;
         energyDivisor <= `AE_RST_DIV;
      end else if (sfrWr) begin
         case (sfrAddr)
            `AE_ADDR_WAVE: waveformSourceSelect <= sfrWrData;
            `AE_ADDR_NOLOAD: lowLoadSetup <= sfrWrData; // R9
            `AE_ADDR_ACC: accumulationSetup <= sfrWrData;
            `AE_ADDR_IRQEN_LO: measureIrqEnableLow <= sfrWrData;
            `AE_ADDR_IRQEN_HI: measureIrqEnableHigh <= sfrWrData;
            `AE_ADDR_GAIN_LO: powerGainWord[7:0] <= sfrWrData;
            `AE_ADDR_GAIN_HI: powerGainWord[11:8] <= sfrWrData[3:0];
            `AE_ADDR_OFS_LO: powerOffsetWord[7:0] <= sfrWrData;
            `AE_ADDR_OFS_HI: powerOffsetWord[15:8] <= sfrWrData;
            `AE_ADDR_DIV: energyDivisor <= sfrWrData; // R15
            default: energyDivisor <= energyDivisor;
         endcase
      end
   end

   // snapshot of the top so multi-byte reads stay coherent
   // the low byte read freezes the top; mid and high come from it
   always @(posedge clk) begin
      if (srst)
         energySnap <= {TW{1'b0}};
      else if (snapRead)
         energySnap <= acc[AW-1:LOW]; // R16 R17 R22
   end

   // read data, one cycle after the read strobe
   reg [7:0] next_rdData;
   always @* begin
      case (sfrAddr)
         `AE_ADDR_WAVE: next_rdData = waveformSourceSelect;
         `AE_ADDR_NOLOAD: next_rdData = lowLoadSetup;
         `AE_ADDR_ACC: next_rdData = accumulationSetup;
         `AE_ADDR_IRQEN_LO: next_rdData = measureIrqEnableLow;
         `AE_ADDR_IRQEN_HI: next_rdData = measureIrqEnableHigh;
         `AE_ADDR_IRQST_LO: next_rdData = measureIrqStatusLow;
         `AE_ADDR_GAIN_LO: next_rdData = powerGainWord[7:0];
         `AE_ADDR_GAIN_HI: next_rdData = {4'h0, powerGainWord[11:8]};
         `AE_ADDR_OFS_LO: next_rdData = powerOffsetWord[7:0];
         `AE_ADDR_OFS_HI: next_rdData = powerOffsetWord[15:8];
         `AE_ADDR_DIV: next_rdData = energyDivisor;
         `AE_ADDR_EN_LO: next_rdData = acc[LOW+7:LOW]; // R16
         `AE_ADDR_EN_MID: next_rdData = energySnap[15:8]; // R16
         `AE_ADDR_EN_HI: next_rdData = energySnap[23:16]; // R16
         `AE_ADDR_RC_LO: next_rdData = acc[LOW+7:LOW]; // R17
         `AE_ADDR_RC_MID: next_rdData = energySnap[15:8]; // R17
         `AE_ADDR_RC_HI: next_rdData = energySnap[23:16]; // R17
         default: next_rdData = 8'h00;
      endcase
   end

   // registered read port
   // data stands between reads, so a slow core may fetch it late
   always @(posedge clk) begin
      if (srst)
         sfrRdData <= 8'h00;
      else if (sfrRd)
         sfrRdData <= next_rdData;
   end
endmodule // active_energy_accumulator

`default_nettype wire

//--- hdl/active_energy_regs.vh
// active_energy_regs.vh: register map, field positions, reset values
// and timing counts of the active energy accumulator.
// assumes: included by bare name by the design files.
`ifndef ACTIVE_ENERGY_REGS_VH
`define ACTIVE_ENERGY_REGS_VH

// byte register addresses on the core's register port
`define AE_ADDR_WAVE 8'h0D
`define AE_ADDR_NOLOAD 8'h0E
`define AE_ADDR_ACC 8'h0F
`define AE_ADDR_IRQEN_LO 8'hD9
`define AE_ADDR_IRQEN_HI 8'hDB
`define AE_ADDR_IRQST_LO 8'hDC
`define AE_ADDR_GAIN_LO 8'h10
`define AE_ADDR_GAIN_HI 8'h11
`define AE_ADDR_OFS_LO 8'h12
`define AE_ADDR_OFS_HI 8'h13
`define AE_ADDR_DIV 8'h14
`define AE_ADDR_EN_LO 8'h15
`define AE_ADDR_EN_MID 8'h16
`define AE_ADDR_EN_HI 8'h17
`define AE_ADDR_RC_LO 8'h18
`define AE_ADDR_RC_MID 8'h19
`define AE_ADDR_RC_HI 8'h1A

// accumulation_setup fields
`define AE_ACC_POS_ONLY 0
`define AE_ACC_ABS 1
`define AE_ACC_SIGN_DIR 2
// low_load_setup field
`define AE_NL_LSB 0
// waveform_source_select fields
`define AE_WAVE_RATE_LSB 0
`define AE_WAVE_SRC_LSB 2
`define AE_WAVE_SRC_ACTIVE 3'h0
// status / enable bit positions (low pair)
`define AE_ST_SIGN 0
`define AE_ST_NOLOAD 1
`define AE_ST_HALF_POS 2
`define AE_ST_HALF_NEG 3
`define AE_ST_OVER 4
`define AE_ST_UNDER 5
`define AE_ST_WAVE 6
// enable high bit
`define AE_EN_WAVE 0

// reset values
`define AE_RST_BYTE 8'h00
`define AE_RST_GAIN 12'h000
`define AE_RST_OFS 16'h0000
`define AE_RST_DIV 8'h00

// arithmetic scaling
`define AE_GAIN_FRAC 12
`define AE_OFS_FRAC 8
`define AE_ACC_WIDTH 49
`define AE_TOTAL_WIDTH 24

// timing
`define AE_ACC_PERIOD 3'd5
`define AE_CLK_HZ 125000000
`define AE_WAVE_RATE_HZ 25600

// no-load thresholds in parts per million of full scale
`define AE_NL_PPM1 150
`define AE_NL_PPM2 75
`define AE_NL_PPM3 37
`define AE_PPM_DEN 1000000

`endif

//--- hdl/power_lowpass.v
// power_lowpass.v: multiplies current by voltage, low-pass filters the
// product and applies the signed gain and offset words.
// assumes: samples arrive on clk with a one-cycle valid strobe.
`timescale 1ns/1ps
`default_nettype none
`include "active_energy_regs.vh"

module power_lowpass #(
   parameter W = 24,
   parameter PW = 32,
   parameter LPF_SHIFT = 6
) (
   input wire clk,
   input wire srst,
   input wire signed [W-1:0] currentSample,
   input wire signed [W-1:0] voltageSample,
   input wire sampleValid,
   input wire [11:0] powerGainWord,
   input wire [15:0] powerOffsetWord,
   output reg signed [PW-1:0] activePower
);
   // instantaneous power, top bits kept
   wire signed [2*W-1:0] prod = currentSample * voltageSample; // R1
   wire signed [PW-1:0] prodTop = prod[2*W-1 -: PW];
   reg signed [PW-1:0] lp;
   wire signed [PW:0] diff = {prodTop[PW-1], prodTop} - {lp[PW-1], lp};
   wire signed [PW:0] step = diff >>> LPF_SHIFT;

   // first-order low-pass extracts the dc term
   always @(posedge clk) begin
      if (srst)
         lp <= {PW{1'b0}};
      else if (sampleValid)
         lp <= lp + step[PW-1:0]; // R1
   end

   // gain: one plus word over 4096
   wire signed [13:0] gainTerm = (14'sh0001 <<< `AE_GAIN_FRAC) +
      {{2{powerGainWord[11]}}, powerGainWord};
   wire signed [PW+13:0] scaled = lp * gainTerm; // R2
   wire signed [PW-1:0] scaledTop = scaled[PW+`AE_GAIN_FRAC-1:
      `AE_GAIN_FRAC];
   // offset carries 8 fraction bits below one power count
   wire signed [PW+7:0] fine = {scaledTop, 8'h00} +
      {{(PW-8){powerOffsetWord[15]}}, powerOffsetWord}; // R3

   // registered active power
   always @(posedge clk) begin
      if (srst)
         activePower <= {PW{1'b0}};
      else
         activePower <= fine[PW+`AE_OFS_FRAC-1:`AE_OFS_FRAC];
   end
endmodule // power_lowpass

`default_nettype wire

//--- tb/active_energy_accumulator_properties.sv
// checker: port-level timing properties of the energy accumulator.
// assumes: bound onto active_energy_accumulator; one clock, srst reset.
`timescale 1ns/1ps
`default_nettype none
module active_energy_accumulator_properties #(
   parameter PW = 32
) (
   input wire clk,
   input wire srst,
   input wire [7:0] sfrAddr,
   input wire [7:0] sfrWrData,
   input wire sfrWr,
   input wire sfrRd,
   input wire [7:0] sfrRdData,
   input wire measIrq,
   input wire signed [PW-1:0] waveSample,
   input wire waveValid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // outputs leave reset quiet
   chk_reset_quiet: assert property (
      $fell(srst) |-> sfrRdData == 8'h00 && !measIrq && waveSample == 0)
      else $error("outputs not cleared by reset");
   // unmapped address reads zero
   chk_unmapped_zero: assert property (
      sfrRd && sfrAddr == 8'h00 |=> sfrRdData == 8'h00)
      else $error("unmapped read not zero");
   // read data stands until the next read
   chk_rd_hold: assert property (
      !sfrRd |=> $stable(sfrRdData))
      else $error("read data moved without a read");
   // gain high byte keeps only its low nibble
   chk_gain_nibble: assert property (
      sfrRd && sfrAddr == 8'h11 |=> sfrRdData[7:4] == 4'h0)
      else $error("gain upper nibble not zero");
   // interrupt is gated by the enables
   chk_irq_gate: assert property (
      sfrWr && sfrAddr == 8'hD9 && sfrWrData == 8'h00 |=> !measIrq)
      else $error("interrupt with enables off");
   // pending interrupt stays until a status or enable write
   chk_irq_hold: assert property (
      measIrq && !(sfrWr && (sfrAddr == 8'hD9 || sfrAddr == 8'hDC))
      |=> measIrq)
      else $error("interrupt dropped by itself");
   // sample marker is one cycle wide
   chk_wave_pulse: assert property (
      waveValid |=> !waveValid)
      else $error("sample marker longer than a cycle");
   // sample only moves with its marker
   chk_wave_stable: assert property (
      !waveValid |-> $stable(waveSample))
      else $error("sample changed without marker");
   // disabled waveform makes no samples
   chk_wave_off: assert property (
      sfrWr && sfrAddr == 8'hDB && !sfrWrData[0] |=> ##1 !waveValid [*8])
      else $error("sample while waveform disabled");
endmodule // active_energy_accumulator_properties

bind active_energy_accumulator active_energy_accumulator_properties #(
   .PW(PW)) u_chk (.clk(clk), .srst(srst), .sfrAddr(sfrAddr),
   .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd),
   .sfrRdData(sfrRdData), .measIrq(measIrq), .waveSample(waveSample),
   .waveValid(waveValid));
`default_nettype wire

//--- tb/sfr_core_model.sv
// partner: the core's side of the byte register port, task driven.
// assumes: requests launch 1 ns after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module sfr_core_model (
   input wire clk,
   input wire [7:0] sfrRdData,
   output logic [7:0] sfrAddr,
   output logic [7:0] sfrWrData,
   output logic sfrWr,
   output logic sfrRd
);
   int gap = 0; // idle cycles before an access, for a slow core
   initial begin
      sfrAddr = 8'h00;
      sfrWrData = 8'h00;
      sfrWr = 1'b0;
      sfrRd = 1'b0;
   end
   // write strobe held through its taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      repeat (gap + 1) @(posedge clk);
      #1;
      sfrAddr = a;
      sfrWrData = d;
      sfrWr = 1'b1;
      @(posedge clk);
      #1;
      sfrWr = 1'b0;
      sfrWrData = ~d; // released bus stops showing the value
      sfrAddr = ~a;
   endtask
   // read strobe; answer taken after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      repeat (gap + 1) @(posedge clk);
      #1;
      sfrAddr = a;
      sfrRd = 1'b1;
      @(posedge clk);
      #1;
      q = sfrRdData;
      sfrRd = 1'b0;
      sfrAddr = ~a;
   endtask
   // status bits clear by writing ones
   task automatic clr(input logic [7:0] m);
      wr(8'hDC, m);
   endtask
endmodule // sfr_core_model
`default_nettype wire

//--- tb/tb_active_energy_accumulator.sv
// bench: registers, energy modes, sign flag and waveform of the block.
// assumes: core model on the register port; samples made here.
`timescale 1ns/1ps
`default_nettype none
module tb_active_energy_accumulator;
   localparam int WD = 8; // shortened waveform divider
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic signed [23:0] currentSample = '0;
   logic signed [23:0] voltageSample = '0;
   logic sampleValid = 1'b0;
   wire [7:0] sfrAddr, sfrWrData, sfrRdData;
   wire sfrWr, sfrRd, measIrq, waveValid;
   wire signed [31:0] waveSample;
   int err_count = 0;
   int total_checks = 0;
   int i, n;
   bit seeded = 1'b0;
   bit holdI = 1'b0; // freezes the current for a steady product
   logic signed [31:0] w;
   logic [7:0] q;
   logic [23:0] e;
   logic [7:0] regs[12] = '{8'h0D, 8'h0E, 8'h0F, 8'hD9, 8'hDB, 8'hDC,
      8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h00};
   int tAcc[9] = '{0, 1, 2, 3, 0, 0, 0, 0, 0};
   int tDiv[9] = '{0, 0, 0, 0, 2, 2, 0, 0, 0};
   int tPw[9] = '{-1, -1, -1, -1, -1, -3, -1, -1, -1};
   int tNl[9] = '{0, 0, 0, 0, 0, 0, 1, 2, 3};
   int thr[4] = '{0, 322122, 161061, 79456};
   always #4 clk = ~clk;
   active_energy_accumulator #(.WAVE_DIV(WD)) u_dut (.clk(clk),
      .srst(srst), .currentSample(currentSample),
      .voltageSample(voltageSample), .sampleValid(sampleValid),
      .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWr(sfrWr),
      .sfrRd(sfrRd), .sfrRdData(sfrRdData), .measIrq(measIrq),
      .waveSample(waveSample), .waveValid(waveValid));
   sfr_core_model u_core (.clk(clk), .sfrRdData(sfrRdData),
      .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWr(sfrWr),
      .sfrRd(sfrRd));
   // random current with zero voltage keeps the product at zero
   // seeded once, in the process that draws the values
   always @(posedge clk) begin
      #1;
      if (!seeded)
         void'($urandom(32'h961B));
      seeded = 1'b1;
      if (!holdI)
         currentSample = 24'($urandom);
      sampleValid = 1'($urandom);
   end
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (err_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clk);
      #1 srst = 1'b1;
      repeat (20) @(posedge clk);
      #1 srst = 1'b0;
   endtask
   // power comes from the offset alone: 256 counts per power count
   task automatic setp(input int p);
      u_core.wr(8'h13, 8'(p));
      repeat (25) @(posedge clk);
   endtask
   task automatic rd_energy(input logic [7:0] a, output logic [23:0] v);
      u_core.rd(a, v[7:0]);
      u_core.rd(a + 8'h01, v[15:8]);
      u_core.rd(a + 8'h02, v[23:16]);
   endtask
   task automatic wait_wave(output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1;
         c++;
         if (c > 1000) begin
            err_count++;
            give_verdict();
         end
      end while (waveValid !== 1'b1);
   endtask
   // energy added per accumulation tick
   function automatic int model_inc(int acc, int dv, int p, int nl);
      int s;
      if (nl != 0 && (p < 0 ? -p : p) < thr[nl])
         return 0;
      s = acc[0] ? (p > 0 ? p : 0) : acc[1] ? (p < 0 ? -p : p) : p;
      return s / (dv == 0 ? 1 : dv);
   endfunction
   initial begin
      do_reset();
      // reset values and refused writes
      foreach (regs[k]) begin
         u_core.rd(regs[k], q);
         check("reset value", q, 8'h00);
      end
      u_core.wr(8'h11, 8'hFF);
      u_core.rd(8'h11, q);
      check("gain high", q, 8'h0F);
      u_core.wr(8'h00, 8'h55);
      u_core.wr(8'h15, 8'h55);
      u_core.rd(8'h00, q);
      check("unmapped", q, 8'h00);
      rd_energy(8'h15, e);
      check("energy write", e, 24'h0);
      // accumulation modes, divisor and no-load
      for (i = 0; i < 9; i++) begin
         do_reset();
         u_core.wr(8'h0F, 8'(tAcc[i]));
         u_core.wr(8'h0E, 8'(tNl[i]));
         u_core.wr(8'h14, 8'(tDiv[i]));
         u_core.wr(8'hD9, 8'h02);
         setp(tPw[i]);
         n = model_inc(tAcc[i], tDiv[i], tPw[i], tNl[i]);
         rd_energy(8'h15, e);
         check("energy", e, n < 0 ? 24'hFFFFFF : 24'h0);
         rd_energy(8'h18, e);
         check("read clear", e, n < 0 ? 24'hFFFFFF : 24'h0);
         rd_energy(8'h15, e);
         check("after clear", e, 24'h0);
         u_core.rd(8'hDC, q);
         check("no-load flag", q[1], tNl[i] != 0);
         check("no-load irq", measIrq, tNl[i] != 0);
      end
      // sign change in both directions, slow core on the second
      for (i = 0; i < 2; i++) begin
         do_reset();
         u_core.gap = i * 2;
         u_core.wr(8'h0F, i ? 8'h04 : 8'h00);
         u_core.wr(8'hD9, 8'h01);
         setp(i ? 1 : -1);
         u_core.clr(8'hFF);
         check("irq idle", measIrq, 1'b0);
         setp(i ? -1 : 1);
         u_core.rd(8'hDC, q);
         check("wrong way", q[0], 1'b0);
         setp(i ? 1 : -1);
         check("sign irq", measIrq, 1'b1);
         u_core.rd(8'hDC, q);
         check("sign flag", q[0], 1'b1);
         u_core.clr(8'h01);
         check("irq cleared", measIrq, 1'b0);
      end
      u_core.gap = 0;
      // waveform rates
      do_reset();
      setp(5);
      u_core.wr(8'hDB, 8'h01);
      for (i = 0; i < 4; i++) begin
         u_core.wr(8'h0D, 8'(i));
         wait_wave(n);
         wait_wave(n);
         check("wave period", n, WD << i);
         check("wave sample", waveSample, 32'h5);
      end
      u_core.rd(8'hDC, q);
      check("wave flag", q[6], 1'b1);
      // another waveform source makes no power samples
      u_core.wr(8'h0D, 8'h04);
      repeat (2) @(posedge clk);
      n = 0;
      repeat (64) begin
         @(posedge clk);
         #1;
         n += waveValid;
      end
      check("wave source", n, 0);
      u_core.wr(8'hDB, 8'h00);
      repeat (100) @(posedge clk);
      // a steady product settles the filter; gain then halves it
      holdI = 1'b1;
      do_reset();
      currentSample = 24'h100000;
      voltageSample = 24'h100000;
      u_core.wr(8'hDB, 8'h01);
      repeat (3000) @(posedge clk);
      wait_wave(n);
      w = 32'sh1000000 - waveSample;
      check("product power", w >= 0 && w < 64, 1'b1);
      w = waveSample;
      u_core.wr(8'h11, 8'h08);
      wait_wave(n);
      wait_wave(n);
      check("gain half", waveSample, w >>> 1);
      give_verdict();
   end
endmodule // tb_active_energy_accumulator
`default_nettype wire
